// File: common/bet_params.svh
`ifndef BET_PARAMS_SVH
`define BET_PARAMS_SVH
// ==========================================
// register offsets
`define BET_OFS_CTRL  8'h00
`define BET_OFS_CMD   8'h04
`define BET_OFS_STAT  8'h08
`define BET_OFS_SWBP  8'h0C
`define BET_OFS_CURS  8'h10
`define BET_OFS_TIDX  8'h14
`define BET_OFS_TRA   8'h18
`define BET_OFS_TRB   8'h1C
`define BET_OFS_EV0   8'h20
`define BET_EV_STEP   8'h10
// ==========================================
// field positions
`define BET_CTL_HWEN  0
`define BET_CTL_TPSEL 1
`define BET_CTL_CMB   2
`define BET_CTL_EVEN  4
`define BET_CMD_GO    0
`define BET_CMD_FREE  1
`define BET_CMD_CURS  2
`define BET_CMD_STOP  3
`define BET_CFG_TYPE  0
`define BET_CFG_COND  2
`define BET_CFG_DIR   5
`define BET_CFG_DCMP  7
`define BET_CFG_CNT   8
`define BET_CFG_BIT   16
`define BET_SWBP_EN   31
// ==========================================
// reset values
`define BET_CTRL_RST  6'h30
`define BET_CFG_RST   20'h00100
// ==========================================
// sixteen-bit special windows
`define BET_W16_A_LO  20'h00126
`define BET_W16_A_HI  20'h0012F
`define BET_W16_B_LO  20'h00146
`define BET_W16_B_HI  20'h0014F
`define BET_W16_C_LO  20'h00156
`define BET_W16_C_HI  20'h0015F
`endif

// File: common/bet_pkg.sv
package bet_pkg;
  // ==========================================
  // target bus status codes
  typedef enum logic [2:0] {
    unit_idle       = 3'h0,
    unit_noncpu     = 3'h1,
    unit_int_ack    = 3'h2,
    fetch_byte_code = 3'h3,
    data_byte_code  = 3'h4,
    fetch_word_code = 3'h5,
    data_word_code  = 3'h6
  } bet_unit_st_t;
  typedef enum logic [2:0] {
    cpu_idle          = 3'h0,
    opcode_byte_code  = 3'h1,
    operand_byte_code = 3'h2,
    opcode_word_code  = 3'h3,
    operand_word_code = 3'h4,
    queue_clear_code  = 3'h5
  } bet_cpu_st_t;
  typedef enum logic [1:0] {
    dir_none  = 2'h0,
    dir_read  = 2'h1,
    dir_write = 2'h2
  } bet_dir_t;
  // ==========================================
  // event setup codes
  typedef enum logic [1:0] {
    ev_fetch = 2'h0,
    ev_data  = 2'h1,
    ev_bit   = 2'h2
  } bet_ev_type_t;
  typedef enum logic [2:0] {
    c_eq = 3'h0, c_ne = 3'h1, c_gt = 3'h2, c_ge = 3'h3,
    c_lt = 3'h4, c_le = 3'h5, c_in = 3'h6, c_out = 3'h7
  } bet_cond_t;
  typedef enum logic [1:0] {
    acc_read = 2'h0, acc_write = 2'h1, acc_either = 2'h2
  } bet_acc_t;
  typedef enum logic [1:0] {
    cmb_and = 2'h0, cmb_same = 2'h1, cmb_or = 2'h2
  } bet_cmb_t;
  typedef enum logic [2:0] {
    cause_none = 3'h0, cause_soft = 3'h1, cause_curs = 3'h2,
    cause_hw   = 3'h3, cause_stop = 3'h4
  } bet_cause_t;
  typedef enum logic {
    st_halt = 1'b0,
    st_run  = 1'b1
  } bet_state_t;
  // ==========================================
  // carriers
  typedef struct packed {
    logic [19:0]  addr;
    logic [15:0]  data;
    logic         upper_byte_lane_enable_n;
    logic         valid_cycle_strobe_n;
    bet_dir_t     dir;
    bet_unit_st_t unit;
    bet_cpu_st_t  cpu;
  } bet_bus_t;
  typedef struct packed {
    logic [19:0]  addr;
    logic [15:0]  data;
    logic         wide;
    logic         upper_byte_lane_enable_n;
    logic         valid_cycle_strobe_n;
    bet_dir_t     dir;
    bet_unit_st_t unit;
    bet_cpu_st_t  cpu;
  } bet_trace_t;
endpackage : bet_pkg

// File: design/bet_monitor.sv
`timescale 1ns/1ps
`include "bet_params.svh"
module bet_monitor #(
  parameter int NEV    = 2,
  parameter int TDEPTH = 65536
) (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic [7:0]      addr_in,
  input  wire logic [31:0]     wdata_in,
  input  wire logic            wr_in,
  input  wire logic            rd_in,
  input  wire bet_pkg::bet_bus_t bus_in,
  input  wire logic            emu_acc_in,
  input  wire logic            dec_valid_in,
  input  wire logic [19:0]     dec_pc_in,
  input  wire logic [19:0]     resume_pc_in,
  output logic [31:0]          rdata_out,
  output logic                 run_out,
  output logic                 tpoint_out
);
  localparam int AW = $clog2(TDEPTH);
  // ==========================================
  // register state
  logic [5:0]            ctrl_r;     // control bits
  logic [20:0]           swbp_r;     // enable + address
  logic [19:0]           curs_r;     // cursor address
  logic [AW-1:0]         tidx_r;     // trace read index
  bet_pkg::bet_state_t   state_r;    // run state
  bet_pkg::bet_cause_t   cause_r;    // last halt cause
  logic                  free_r;     // free run active
  logic                  curs_arm_r; // cursor stop armed
  logic                  skip_r;     // step past start bp
  logic                  pend_r;     // hw break pending
  logic                  tdone_r;    // trace finished
  logic                  tfull_r;    // trace wrapped
  logic [AW-1:0]         wptr_r;     // trace write pointer
  logic                  brk_d_r;    // combiner delayed
  bet_pkg::bet_trace_t   tmem [TDEPTH]; // trace memory
  // ==========================================
  // decode
  wire running = (state_r == bet_pkg::st_run);
  wire wr_ctrl = wr_in & (addr_in == `BET_OFS_CTRL);
  wire wr_cmd  = wr_in & (addr_in == `BET_OFS_CMD);
  wire wr_swbp = wr_in & (addr_in == `BET_OFS_SWBP);
  wire wr_curs = wr_in & (addr_in == `BET_OFS_CURS);
  wire wr_tidx = wr_in & (addr_in == `BET_OFS_TIDX);
  wire go_any  = wdata_in[`BET_CMD_GO] | wdata_in[`BET_CMD_FREE]
               | wdata_in[`BET_CMD_CURS];
  wire arm     = wr_cmd & ~running & go_any;
  wire stop_w  = wr_cmd & running & wdata_in[`BET_CMD_STOP];
  wire hw_en   = ctrl_r[`BET_CTL_HWEN];
  wire tp_sel  = ctrl_r[`BET_CTL_TPSEL];
  wire [1:0] cmb = ctrl_r[`BET_CTL_CMB +: 2];
  wire [NEV-1:0] ev_en = ctrl_r[`BET_CTL_EVEN +: NEV];
  wire same_m  = (cmb == bet_pkg::cmb_same);
  // qualified cpu bus cycle
  wire vld   = ~bus_in.valid_cycle_strobe_n & ~emu_acc_in;
  wire is_f  = (bus_in.unit == bet_pkg::fetch_byte_code)
             | (bus_in.unit == bet_pkg::fetch_word_code);
  wire is_d  = (bus_in.unit == bet_pkg::data_byte_code)
             | (bus_in.unit == bet_pkg::data_word_code);
  // ==========================================
  // address condition forms
  function automatic logic amatch(input logic [2:0] c,
    input logic [19:0] a, input logic [19:0] lo,
    input logic [19:0] hi);
    logic inr;
    inr = (a >= lo) & (a <= hi);
    case (c)
      bet_pkg::c_eq:  amatch = (a == lo);
      bet_pkg::c_ne:  amatch = (a != lo);
      bet_pkg::c_gt:  amatch = (a > lo);
      bet_pkg::c_ge:  amatch = (a >= lo);
      bet_pkg::c_lt:  amatch = (a < lo);
      bet_pkg::c_le:  amatch = (a <= lo);
      bet_pkg::c_in:  amatch = inr;
      default:        amatch = ~inr;
    endcase
  endfunction : amatch
  // ==========================================
  // event channels
  logic [NEV-1:0] ev_hit;              // matched this cycle
  logic [NEV-1:0] ev_sat;              // pass count reached
  logic [31:0]    ev_rd [NEV];         // gated read words
  genvar g;
  for (g = 0; g < NEV; g++) begin : g_ev
    localparam logic [7:0] EVB = 8'(`BET_OFS_EV0 + g * `BET_EV_STEP);
    logic [19:0] cfg_r;                // type/cond/dir/count
    logic [19:0] lo_r;                 // low address
    logic [19:0] hi_r;                 // high address
    logic [15:0] dat_r;                // compare data
    logic [7:0]  cnt_r;                // passes left
    logic        sat_r;                // satisfied
    wire sel = (addr_in[7:4] == EVB[7:4]);
    wire [1:0] ix = addr_in[3:2];
    wire [1:0] ty = cfg_r[`BET_CFG_TYPE +: 2];
    wire [1:0] dq = cfg_r[`BET_CFG_DIR +: 2];
    wire dcmp = cfg_r[`BET_CFG_DCMP];
    wire [7:0] pc = cfg_r[`BET_CFG_CNT +: 8];
    wire [3:0] bp = cfg_r[`BET_CFG_BIT +: 4];
    wire am = amatch(cfg_r[`BET_CFG_COND +: 3], bus_in.addr,
                     lo_r, hi_r);
    // direction qualifier
    wire dir_ok = (dq == bet_pkg::acc_either)
      | ((dq == bet_pkg::acc_read) & (bus_in.dir == bet_pkg::dir_read))
      | ((dq == bet_pkg::acc_write) & (bus_in.dir == bet_pkg::dir_write));
    wire d_ok = ~dcmp | (bus_in.data == dat_r);
    wire b_ok = ~dcmp | (bus_in.data[bp] == dat_r[bp]);
    // kind selection
    wire kind = (ty == bet_pkg::ev_fetch) ? (is_f & am)
              : (ty == bet_pkg::ev_data)  ? (is_d & am & dir_ok & d_ok)
              : (ty == bet_pkg::ev_bit)
                ? (is_d & (bus_in.addr == lo_r) & dir_ok & b_ok)
              : 1'b0;
    assign ev_hit[g] = ev_en[g] & vld & kind & running;
    assign ev_sat[g] = sat_r;
    assign ev_rd[g]  = ~sel ? 32'h00000000
                     : (ix == 2'h0) ? {12'h000, cfg_r}
                     : (ix == 2'h1) ? {12'h000, lo_r}
                     : (ix == 2'h2) ? {12'h000, hi_r}
                     : {16'h0000, dat_r};
    // setup registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        cfg_r <= `BET_CFG_RST;
        lo_r  <= 20'h00000;
        hi_r  <= 20'h00000;
        dat_r <= 16'h0000;
      end else if (wr_in & sel) begin
        case (ix)
          2'h0:    cfg_r <= wdata_in[19:0];
          2'h1:    lo_r  <= wdata_in[19:0];
          2'h2:    hi_r  <= wdata_in[19:0];
          default: dat_r <= wdata_in[15:0];
        endcase
      end
    end
    // pass counter
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        cnt_r <= 8'h01;
        sat_r <= 1'b0;
      end else if (arm) begin
        cnt_r <= (pc == 8'h00) ? 8'h01 : pc;
        sat_r <= 1'b0;
      end else if (ev_hit[g] & ~sat_r) begin
        if (same_m | (cnt_r <= 8'h01)) begin
          sat_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
  // ==========================================
  // combiner
  wire any_en = |ev_en;
  wire brk_w  = any_en & (
      (cmb == bet_pkg::cmb_and)  ? &(ev_sat | ~ev_en)
    : (cmb == bet_pkg::cmb_same) ? &(ev_hit | ~ev_en)
    : (cmb == bet_pkg::cmb_or)   ? |(ev_sat & ev_en)
    : 1'b0);
  wire hw_arm = running & hw_en & ~tp_sel & ~free_r;
  // ==========================================
  // halt sources
  wire sw_hit  = running & ~free_r & dec_valid_in & swbp_r[20]
               & (dec_pc_in == swbp_r[19:0]) & ~skip_r;
  wire cur_hit = running & ~free_r & dec_valid_in & curs_arm_r
               & (dec_pc_in == curs_r) & ~skip_r;
  wire hw_hit  = running & pend_r & dec_valid_in;
  wire halt_w  = stop_w | sw_hit | cur_hit | hw_hit;
  bet_pkg::bet_cause_t cause_w;
  assign cause_w = sw_hit  ? bet_pkg::cause_soft
                 : cur_hit ? bet_pkg::cause_curs
                 : hw_hit  ? bet_pkg::cause_hw
                 : bet_pkg::cause_stop;
  // ==========================================
  // control registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= `BET_CTRL_RST;
      swbp_r <= 21'h000000;
      curs_r <= 20'h00000;
      tidx_r <= '0;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata_in[5:0];
      if (wr_swbp) swbp_r <= {wdata_in[`BET_SWBP_EN], wdata_in[19:0]};
      if (wr_curs) curs_r <= wdata_in[19:0];
      if (wr_tidx) tidx_r <= wdata_in[AW-1:0];
    end
  end
  // ==========================================
  // run state machine
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r    <= bet_pkg::st_halt;
      cause_r    <= bet_pkg::cause_none;
      free_r     <= 1'b0;
      curs_arm_r <= 1'b0;
      skip_r     <= 1'b0;
    end else begin
      case (state_r)
        bet_pkg::st_halt: begin
          if (arm) begin
            state_r    <= bet_pkg::st_run;
            cause_r    <= bet_pkg::cause_none;
            free_r     <= wdata_in[`BET_CMD_FREE];
            curs_arm_r <= wdata_in[`BET_CMD_CURS];
            skip_r     <= swbp_r[20] & (resume_pc_in == swbp_r[19:0]);
          end
        end
        bet_pkg::st_run: begin
          if (dec_valid_in) skip_r <= 1'b0;
          if (halt_w) begin
            state_r    <= bet_pkg::st_halt;
            cause_r    <= cause_w;
            curs_arm_r <= 1'b0;
          end
        end
        default: state_r <= bet_pkg::st_halt;
      endcase
    end
  end
  // ==========================================
  // hardware break pending, trace point pulse
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend_r     <= 1'b0;
      brk_d_r    <= 1'b0;
      tpoint_out <= 1'b0;
    end else begin
      if (arm | ~running) pend_r <= 1'b0;
      else if (hw_arm & brk_w) pend_r <= 1'b1;
      brk_d_r    <= brk_w & running;
      tpoint_out <= tp_sel & running & brk_w & ~brk_d_r;
    end
  end
  // ==========================================
  // trace record build
  // sixteen-bit windows, everything else reports eight bits
  wire a_w16 =
      ((bus_in.addr >= `BET_W16_A_LO) & (bus_in.addr <= `BET_W16_A_HI))
    | ((bus_in.addr >= `BET_W16_B_LO) & (bus_in.addr <= `BET_W16_B_HI))
    | ((bus_in.addr >= `BET_W16_C_LO) & (bus_in.addr <= `BET_W16_C_HI));
  bet_pkg::bet_trace_t rec_w;
  assign rec_w.addr = bus_in.addr;
  assign rec_w.data = bus_in.data;
  assign rec_w.wide = a_w16;
  assign rec_w.upper_byte_lane_enable_n =
           bus_in.upper_byte_lane_enable_n;
  assign rec_w.valid_cycle_strobe_n = bus_in.valid_cycle_strobe_n;
  assign rec_w.dir  = bus_in.dir;
  assign rec_w.unit = emu_acc_in ? bet_pkg::unit_noncpu
                                 : bus_in.unit;
  assign rec_w.cpu  = bus_in.cpu;
  // ==========================================
  // trace capture, ring of latest cycles
  always_ff @(posedge clk_in) begin
    if (running) tmem[wptr_r] <= rec_w;
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wptr_r  <= '0;
      tfull_r <= 1'b0;
      tdone_r <= 1'b0;
    end else if (arm) begin
      wptr_r  <= '0;
      tfull_r <= 1'b0;
      tdone_r <= 1'b0;
    end else if (running) begin
      wptr_r  <= wptr_r + 1'b1;
      if (&wptr_r) tfull_r <= 1'b1;
      if (halt_w) tdone_r <= 1'b1;
    end
  end
  // ==========================================
  // read path
  wire [AW-1:0] old_ix = tfull_r ? wptr_r : '0;
  wire [AW-1:0] rd_ix  = old_ix + tidx_r;
  bet_pkg::bet_trace_t trec;
  assign trec = tmem[rd_ix];
  wire t_ok = tdone_r & ~running;
  wire [31:0] tra_w = t_ok ? {12'h000, trec.addr} : 32'h00000000;
  // data on top, status bits (wide down to cpu code) in the low eleven
  wire [31:0] trb_w = t_ok ? {trec.data, 5'h00, trec[10:0]}
                           : 32'h00000000;
  wire [31:0] stat_w = {24'h000000, tp_sel, cause_r,
                        tdone_r, tfull_r, pend_r, running};
  logic [31:0] ev_word;
  always_comb begin
    ev_word = 32'h00000000;
    for (int i = 0; i < NEV; i++) ev_word = ev_word | ev_rd[i];
  end
  wire [31:0] rd_word =
      (addr_in == `BET_OFS_CTRL) ? {26'h0000000, ctrl_r}
    : (addr_in == `BET_OFS_STAT) ? stat_w
    : (addr_in == `BET_OFS_SWBP) ? {swbp_r[20], 11'h000, swbp_r[19:0]}
    : (addr_in == `BET_OFS_CURS) ? {12'h000, curs_r}
    : (addr_in == `BET_OFS_TIDX) ? {tfull_r, 31'(wptr_r)}
    : (addr_in == `BET_OFS_TRA)  ? tra_w
    : (addr_in == `BET_OFS_TRB)  ? trb_w
    : ev_word;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h00000000;
      run_out   <= 1'b0;
    end else begin
      rdata_out <= rd_in ? rd_word : 32'h00000000;
      run_out   <= running & ~halt_w;
    end
  end
  // ==========================================
  // checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_soft_halt_before: assert property (sw_hit |=> !run_out)
    else $error("soft break did not halt");
  a_skip_start_bp: assert property (running && skip_r && dec_valid_in
    && !stop_w && !hw_hit |=> run_out)
    else $error("start breakpoint not stepped over");
  a_free_no_break: assert property (running && free_r && !stop_w
    |=> running)
    else $error("free run was halted by a break");
  a_cursor_halt: assert property (cur_hit |=> !running && !run_out)
    else $error("cursor run did not halt");
  a_hw_after_insn: assert property (pend_r && running && !dec_valid_in
    && !stop_w && !sw_hit && !cur_hit |=> running)
    else $error("hw break halted mid instruction");
  a_hw_gate_enable: assert property ($rose(pend_r)
    |-> $past(hw_en) && !$past(tp_sel))
    else $error("hw break without global enable");
  a_trace_blank_run: assert property (rd_in && running
    && (addr_in == `BET_OFS_TRA) |=> rdata_out == 32'h00000000)
    else $error("trace shown during acquisition");
  a_trace_one_rec: assert property (running && !arm
    |=> wptr_r == $past(wptr_r) + 1'b1)
    else $error("trace pointer skipped a cycle");
  a_emu_tag_noncpu: assert property (emu_acc_in
    |-> rec_w.unit == bet_pkg::unit_noncpu)
    else $error("emulator access not tagged");
  c_soft_break: cover property (sw_hit ##1 !run_out);
  c_hw_break: cover property (pend_r ##[1:20] hw_hit);
  c_trace_read: cover property (t_ok && rd_in
    && (addr_in == `BET_OFS_TRB));
endmodule : bet_monitor

// File: test/bet_core_model.sv
`timescale 1ns/1ps
// ==========================================
// target core model: issue, wait, commit
module bet_core_model (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         run_in,
  output bet_pkg::bet_bus_t bus_out,
  output logic              dec_valid_out,
  output logic [19:0]       pc_out
);
  logic [1:0]        ph_r;    // instruction phase
  bet_pkg::bet_bus_t idle_w;  // released bus, scrambled values
  bet_pkg::bet_bus_t fetch_w; // opcode fetch at pc
  bet_pkg::bet_bus_t wr_w;    // data write at pc plus 0x100
  assign idle_w = '{addr: ~bus_out.addr, data: ~bus_out.data,
    upper_byte_lane_enable_n: 1'b1, valid_cycle_strobe_n: 1'b1,
    dir: bet_pkg::dir_none, unit: bet_pkg::unit_idle,
    cpu: bet_pkg::cpu_idle};
  assign fetch_w = '{addr: pc_out, data: pc_out[15:0],
    upper_byte_lane_enable_n: ~pc_out[0], valid_cycle_strobe_n: 1'b0,
    dir: bet_pkg::dir_read, unit: bet_pkg::fetch_byte_code,
    cpu: bet_pkg::opcode_byte_code};
  assign wr_w = '{addr: pc_out + 20'h00100, data: pc_out[15:0],
    upper_byte_lane_enable_n: ~pc_out[0], valid_cycle_strobe_n: 1'b0,
    dir: bet_pkg::dir_write, unit: bet_pkg::data_byte_code,
    cpu: bet_pkg::cpu_idle};
  // ==========================================
  // commit only if still allowed to run a cycle after decode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_r <= 2'h0;
      pc_out <= 20'h00000;
      dec_valid_out <= 1'b0;
      bus_out <= bet_pkg::bet_bus_t'({36'h0, 2'h3, 8'h00});
    end else if (ph_r == 2'h0) begin
      dec_valid_out <= run_in;
      bus_out <= run_in ? fetch_w : idle_w;
      ph_r <= run_in ? 2'h1 : 2'h0;
    end else if (ph_r == 2'h1) begin
      dec_valid_out <= 1'b0;
      bus_out <= idle_w;
      ph_r <= 2'h2;
    end else begin
      bus_out <= run_in ? wr_w : idle_w;
      pc_out <= run_in ? pc_out + 20'h00001 : pc_out;
      ph_r <= 2'h0;
    end
  end
endmodule : bet_core_model

// File: test/tb.sv
`timescale 1ns/1ps
`include "bet_params.svh"
module tb;
  // ==========================================
  // signals
  logic              clk_in, rst_n_in, wr_in, rd_in, run_out, tpoint_out;
  logic              dec_valid, tp_seen, emu;
  logic [7:0]        addr_in;
  logic [31:0]       wdata_in, rdata_out;
  logic [19:0]       pc;
  bet_pkg::bet_bus_t bus;
  int                n_fail, samples_checked;
  bet_monitor #(.NEV(2), .TDEPTH(16)) u_dut (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .bus_in(bus), .emu_acc_in(emu),
    .dec_valid_in(dec_valid), .dec_pc_in(pc), .resume_pc_in(pc),
    .rdata_out(rdata_out), .run_out(run_out), .tpoint_out(tpoint_out));
  bet_core_model u_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .run_in(run_out), .bus_out(bus), .dec_valid_out(dec_valid),
    .pc_out(pc));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) if (tpoint_out === 1'b1) tp_seen <= 1'b1;
  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  task automatic arm(input logic [31:0] c);
    wr(`BET_OFS_CMD, c);
    repeat (2) @(posedge clk_in);
    #1 chk("run", 32'h1, {31'h0, run_out});
  endtask : arm
  task automatic halt_wait(input int n);
    int i;
    i = 0;
    while (run_out !== 1'b0 && i < n) begin
      @(posedge clk_in);
      #1 i++;
    end
  endtask : halt_wait
  task automatic cause_is(input logic [2:0] c);
    logic [31:0] d;
    rd(`BET_OFS_STAT, d);
    chk("cause", {29'h0, c}, {29'h0, d[6:4]});
  endtask : cause_is
  task automatic stop_chk();
    wr(`BET_OFS_CMD, 32'h8);
    halt_wait(20);
    cause_is(3'h4);
  endtask : stop_chk
  task automatic pc_in(input logic [19:0] x);
    chk("halt pc", 32'h1, {31'h0, pc >= x + 20'h1 && pc <= x + 20'h2});
  endtask : pc_in
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    @(posedge clk_in);
    #1 chk("run", 32'h0, {31'h0, run_out});
    rd(`BET_OFS_CTRL, d);
    chk("ctrl", {26'h0, `BET_CTRL_RST}, d);
    rd(`BET_OFS_EV0, d);
    chk("cfg", {12'h0, `BET_CFG_RST}, d);
    rd(8'hFC, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
  endtask : t_reset
  task automatic t_trace();
    logic [31:0] d, a, b;
    logic [19:0] prev;
    logic        w;
    int          ne;
    prev = 20'h0;
    ne = 0;
    wr(`BET_OFS_CURS, 32'h28);
    arm(32'h4);
    rd(`BET_OFS_TRA, d);
    chk("trace busy", 32'h0, d);
    // emulator cycle laid over the fetch of 0x27
    wait (pc == 20'h27);
    @(posedge clk_in);
    emu <= 1'b1;
    @(posedge clk_in);
    emu <= 1'b0;
    halt_wait(400);
    chk("pc", 32'h28, {12'h0, pc});
    cause_is(3'h2);
    rd(`BET_OFS_STAT, d);
    chk("done", 32'h1, {31'h0, d[3]});
    for (int i = 0; i < 16; i++) begin
      wr(`BET_OFS_TIDX, i);
      rd(`BET_OFS_TRA, a);
      rd(`BET_OFS_TRB, b);
      if (b[8] === 1'b0) begin
        w = (a[19:0] >= `BET_W16_A_LO && a[19:0] <= `BET_W16_A_HI) ||
            (a[19:0] >= `BET_W16_B_LO && a[19:0] <= `BET_W16_B_HI) ||
            (a[19:0] >= `BET_W16_C_LO && a[19:0] <= `BET_W16_C_HI);
        chk("wide", {31'h0, w}, {31'h0, b[10]});
        chk("lane", {31'h0, ~a[0]}, {31'h0, b[9]});
        if (b[5:3] === bet_pkg::unit_noncpu) begin
          ne++;
          chk("emu addr", 32'h27, a);
        end else if (b[5:3] === bet_pkg::fetch_byte_code) begin
          chk("cpu", {29'h0, bet_pkg::opcode_byte_code}, b[2:0]);
          chk("order", 32'h1, {31'h0, a[19:0] > prev});
          prev = a[19:0];
        end else begin
          chk("unit", {29'h0, bet_pkg::data_byte_code}, b[5:3]);
          chk("dir", {30'h0, bet_pkg::dir_write}, b[7:6]);
          chk("data", a - 32'h100, {16'h0, b[31:16]});
        end
      end else begin
        chk("idle unit", 32'h0, {29'h0, b[5:3]});
      end
    end
    chk("emu seen", 32'h1, ne);
    $display("test trace done");
  endtask : t_trace
  task automatic t_soft();
    wr(`BET_OFS_SWBP, 32'h8000002B);
    arm(32'h1);
    halt_wait(100);
    chk("pc", 32'h2B, {12'h0, pc});
    cause_is(3'h1);
    arm(32'h1);
    repeat (30) @(posedge clk_in);
    #1 chk("pc past", 32'h1, {31'h0, pc > 20'h2B});
    chk("run", 32'h1, {31'h0, run_out});
    stop_chk();
    wr(`BET_OFS_SWBP, {12'h800, pc + 20'h3});
    arm(32'h2);
    repeat (40) @(posedge clk_in);
    #1 chk("free run", 32'h1, {31'h0, run_out});
    stop_chk();
    wr(`BET_OFS_SWBP, 32'h0);
    $display("test software break done");
  endtask : t_soft
  task automatic t_count();
    logic [19:0] s;
    s = pc + 20'h2;
    wr(`BET_OFS_EV0, 32'h339);
    wr(`BET_OFS_EV0 + 8'h4, {12'h0, s + 20'h100});
    wr(`BET_OFS_EV0 + 8'h8, 32'hFFFFF);
    wr(`BET_OFS_CTRL, 32'h19);
    arm(32'h1);
    halt_wait(100);
    pc_in(s + 20'h2);
    cause_is(3'h3);
    $display("test pass count done");
  endtask : t_count
  task automatic t_combine();
    logic [31:0] ctl [5];
    logic [1:0]  hit [5];
    logic [19:0] p, q;
    ctl = '{32'h31, 32'h35, 32'h39, 32'h3B, 32'h38};
    hit = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
    for (int k = 0; k < 5; k++) begin
      p = pc + 20'h3;
      q = pc + 20'h6;
      wr(`BET_OFS_EV0, 32'h100);
      wr(`BET_OFS_EV0 + 8'h4, {12'h0, p});
      wr(`BET_OFS_EV0 + `BET_EV_STEP, 32'h121);
      wr(`BET_OFS_EV0 + `BET_EV_STEP + 8'h4, {12'h0, q + 20'h100});
      wr(`BET_OFS_CTRL, ctl[k]);
      tp_seen = 1'b0;
      arm(32'h1);
      halt_wait(60);
      if (hit[k] == 2'h0) begin
        chk("no break", 32'h1, {31'h0, run_out});
        stop_chk();
      end else begin
        pc_in(hit[k] == 2'h1 ? p : q);
        cause_is(3'h3);
      end
      if (k == 3) begin
        chk("trace point", 32'h1, {31'h0, tp_seen});
      end
    end
    $display("test combiner done");
  endtask : t_combine
  // ==========================================
  // verdict, watchdog and main sequence
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    tp_seen = 1'b0;
    emu = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_trace();
    t_soft();
    t_count();
    t_combine();
    test_done();
  end
endmodule : tb
